// >>> rtl/multi_queue_read_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Double-rate select high reads on both read clock edges when enabled.
// - Double rate samples enables at rising edge; falling edge read follows regardless.
// - Single rate reads only on rising edges with enable and select low.
// - Low drive enable drives output register; high floats the queue lanes.
// - During resets only drive enable, power-down and unused dual-mode lanes float outputs; chip select ignored.
// - Power-down is active low; device stays down while held low.
// - Power-down freezes memory, pointers, flags, offsets, queue counts; clears the resume counter; ignores inputs except the resets.
// - Power-down floats data outputs and serial output.
// - After power-down release wait 1us; device resumes without reset.
// - Serial write enable low shifts one input bit per serial clock rise.
// - Serial write enable high leaves offsets unchanged.
// - Serial read enable falling copies offsets; one bit out per rise.
// - Serial read enable high stops readout; next low recopies.
// - Quad mode maps queues 0..3 to 10-bit lanes in order.
// - Dual mode maps queues 0 and 2 to 20 or 10 bit lanes.
// - Serial-in pin level at master reset selects standard or fall-through.
// - Standard empty flag low while empty and blocks reads.
// - Fall-through ready flag falls when first word reaches outputs.
// - Extra read after last word raises ready; data stays; reads blocked.
// - Flags update on read clock rise, two or three stages.
// - Standard empty flag rises two read cycles after a write.
// - Chip select high floats lanes and blocks reads at next rise.
module multi_queue_read_ctrl (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic partialResetN,
   // Static configuration
   input wire logic read_double_rate_select,
   input wire logic quadMode,
   input wire logic dualWide,
   input wire logic power_down_n,
   // Per-queue read port
   input wire logic [3:0] readClk,
   input wire logic [3:0] readEnableN,
   input wire logic [3:0] read_chip_select_n,
   input wire logic [3:0] outputEnableN,
   // Per-queue write feed
   input wire logic [3:0] wrValid,
   input wire logic [3:0][19:0] wrData,
   output logic [3:0] wrReady,
   // Output bus
   output logic [39:0] queueData,
   output logic [39:0] queueDataOeN,
   output logic [3:0] empty_flag_n,
   output logic resumeReady,
   // Serial offset port
   input wire logic serialClk,
   input wire logic fall_through_or_serial_in,
   input wire logic offset_shift_write_enable_n,
   input wire logic offset_shift_read_enable_n,
   output logic offset_serial_out,
   output logic offsetSerialOutOeN,
   output logic [127:0] offsetValues
);
   logic [1:0] rstPipe_reg;
   logic rstSync;
   logic fall_through_mode;
   mq_pkg::bus_mode_t mode_reg;
   logic pdActive;
   logic [4:0] resumeCnt_reg;
   logic [3:0] driveN;
   logic [3:0][19:0] outData;

   ////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rstPipe_reg <= 2'h0;
      end else begin
         rstPipe_reg <= {rstPipe_reg[0], 1'b1};
      end
   end

   assign rstSync = rstPipe_reg[1];

   ////////////////////////////////////////////////////////////
   // Straps caught while master reset is held
   always_ff @(posedge core_clk) begin
      if (!rstSync) begin
         fall_through_mode <= fall_through_or_serial_in;
         if (quadMode) begin
            mode_reg <= mq_pkg::MODE_QUAD;
         end else if (dualWide) begin
            mode_reg <= mq_pkg::MODE_DUAL20;
         end else begin
            mode_reg <= mq_pkg::MODE_DUAL10;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Power-down and resume wait
   assign pdActive = !power_down_n;

   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         resumeCnt_reg <= mq_pkg::PD_RESUME_CNT;
      end else if (pdActive) begin
         resumeCnt_reg <= 5'h00;
      end else if (resumeCnt_reg != mq_pkg::PD_RESUME_CNT) begin
         resumeCnt_reg <= resumeCnt_reg + 5'h01;
      end
   end

   assign resumeReady = !pdActive && (resumeCnt_reg == mq_pkg::PD_RESUME_CNT);

   ////////////////////////////////////////////////////////////
   // Queue read lanes
   for (genvar i = 0; i < mq_pkg::NUM_Q; i++) begin : g_queue
      logic [19:0] mem [mq_pkg::DEPTH];
      logic rclkPrev_reg;
      logic ddrArm_reg;
      logic csOn_reg;
      logic [1:0] flagPipe_reg;
      logic [mq_pkg::PTR_W-1:0] wrPtr_reg;
      logic [mq_pkg::PTR_W-1:0] rdPtr_reg;
      logic [mq_pkg::CNT_W-1:0] count_reg;
      logic [mq_pkg::CNT_W-1:0] count_next;
      logic [19:0] outData_reg;
      logic outValid_reg;
      logic active;
      logic rise;
      logic fall;
      logic takeRise;
      logic readReq;
      logic nonEmpty;
      logic avail;
      logic wrAccept;
      logic popStd;
      logic loadFwft;
      logic dropFwft;
      logic pop;

      assign active = (mode_reg == mq_pkg::MODE_QUAD) || (i % 2 == 0);

      // Read clock edges are ignored in power-down
      assign rise = !pdActive && readClk[i] && !rclkPrev_reg;
      assign fall = !pdActive && !readClk[i] && rclkPrev_reg;

      assign takeRise = rise && !readEnableN[i] && !read_chip_select_n[i];
      assign readReq = takeRise || (fall && ddrArm_reg);

      assign nonEmpty = (count_reg != '0);
      // Fall-through uses the output register as its third stage
      assign avail = fall_through_mode ? flagPipe_reg[mq_pkg::FLAG_STAGES_FALL_THROUGH_MODE-2]
                                       : flagPipe_reg[mq_pkg::FLAG_STAGES_STD-1];

      assign wrReady[i] = !pdActive && active && (count_reg != mq_pkg::DEPTH_CNT);
      assign wrAccept = wrValid[i] && wrReady[i];

      // Standard: reads blocked while the flag shows empty
      assign popStd = !fall_through_mode && readReq && avail && nonEmpty;
      // Fall-through: first word moves to outputs on its own
      assign loadFwft = fall_through_mode && avail && nonEmpty &&
                        ((rise && !outValid_reg) || (readReq && outValid_reg));
      assign dropFwft = fall_through_mode && readReq && outValid_reg && !(avail && nonEmpty);
      assign pop = popStd || loadFwft;

      always_comb begin
         count_next = count_reg;
         if (wrAccept && !pop) begin
            count_next = count_reg + 5'h01;
         end else if (pop && !wrAccept) begin
            count_next = count_reg - 5'h01;
         end
      end

      ////////////////////////////////////////////////////////
      // Storage
      always_ff @(posedge core_clk) begin
         if (wrAccept) begin
            mem[wrPtr_reg] <= wrData[i];
         end
      end

      always_ff @(posedge core_clk or negedge rstSync) begin
         if (!rstSync) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
         end else if (!partialResetN) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
         end else begin
            if (wrAccept) begin
               wrPtr_reg <= wrPtr_reg + 4'h1;
            end
            if (pop) begin
               rdPtr_reg <= rdPtr_reg + 4'h1;
            end
            count_reg <= count_next;
         end
      end

      ////////////////////////////////////////////////////////
      // Read clock tracking and double-rate arm
      always_ff @(posedge core_clk or negedge rstSync) begin
         if (!rstSync) begin
            rclkPrev_reg <= 1'b0;
            ddrArm_reg <= 1'b0;
         end else if (!pdActive) begin
            rclkPrev_reg <= readClk[i];
            if (rise) begin
               ddrArm_reg <= read_double_rate_select && !readEnableN[i] &&
                             !read_chip_select_n[i];
            end else if (fall) begin
               ddrArm_reg <= 1'b0;
            end
         end
      end

      ////////////////////////////////////////////////////////
      // Flag stages and chip select, on read clock rise
      always_ff @(posedge core_clk or negedge rstSync) begin
         if (!rstSync) begin
            flagPipe_reg <= 2'h0;
            csOn_reg <= 1'b1;
         end else if (!partialResetN) begin
            flagPipe_reg <= 2'h0;
            csOn_reg <= 1'b1;
         end else if (rise) begin
            flagPipe_reg <= {flagPipe_reg[0], nonEmpty};
            csOn_reg <= !read_chip_select_n[i];
         end
      end

      ////////////////////////////////////////////////////////
      // Output register
      always_ff @(posedge core_clk or negedge rstSync) begin
         if (!rstSync) begin
            outData_reg <= 20'h00000;
            outValid_reg <= 1'b0;
         end else if (!partialResetN) begin
            outData_reg <= 20'h00000;
            outValid_reg <= 1'b0;
         end else if (pop) begin
            outData_reg <= mem[rdPtr_reg];
            outValid_reg <= 1'b1;
         end else if (dropFwft) begin
            outValid_reg <= 1'b0;
         end
      end

      assign outData[i] = outData_reg;
      // Flags hold through power-down since count and stages freeze
      assign empty_flag_n[i] = fall_through_mode ? !outValid_reg
                                                 : (avail && nonEmpty);
      // Per-queue drive, low while driving
      assign driveN[i] = outputEnableN[i] || pdActive || !csOn_reg || !active;
   end

   ////////////////////////////////////////////////////////////
   // Output bus lane mapping
   always_comb begin
      queueData = 40'h0000000000;
      queueDataOeN = {40{1'b1}};
      case (mode_reg)
         mq_pkg::MODE_QUAD: begin
            for (int q = 0; q < mq_pkg::NUM_Q; q++) begin
               queueData[q*mq_pkg::LANE_W +: mq_pkg::LANE_W] = outData[q][9:0];
               queueDataOeN[q*mq_pkg::LANE_W +: mq_pkg::LANE_W] = {10{driveN[q]}};
            end
         end
         mq_pkg::MODE_DUAL20: begin
            queueData[mq_pkg::Q0_BASE +: mq_pkg::WORD_W] = outData[0];
            queueDataOeN[mq_pkg::Q0_BASE +: mq_pkg::WORD_W] = {20{driveN[0]}};
            queueData[mq_pkg::Q2_BASE +: mq_pkg::WORD_W] = outData[2];
            queueDataOeN[mq_pkg::Q2_BASE +: mq_pkg::WORD_W] = {20{driveN[2]}};
         end
         mq_pkg::MODE_DUAL10: begin
            queueData[mq_pkg::Q0_BASE +: mq_pkg::LANE_W] = outData[0][9:0];
            queueDataOeN[mq_pkg::Q0_BASE +: mq_pkg::LANE_W] = {10{driveN[0]}};
            queueData[mq_pkg::Q2_BASE +: mq_pkg::LANE_W] = outData[2][9:0];
            queueDataOeN[mq_pkg::Q2_BASE +: mq_pkg::LANE_W] = {10{driveN[2]}};
         end
         default: begin
            queueData = 40'h0000000000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////
   // Serial offset port
   offset_port_if sp ();

   assign sp.sclk = serialClk;
   assign sp.serialIn = fall_through_or_serial_in;
   assign sp.swenN = offset_shift_write_enable_n;
   assign sp.srenN = offset_shift_read_enable_n;
   assign sp.pdActive = pdActive;

   offset_serial_port u_offsets (
      .clk(core_clk),
      .rstN(rstSync),
      .sp(sp.port)
   );

   assign offset_serial_out = sp.serialOut;
   assign offsetSerialOutOeN = sp.serialOutOeN;
   assign offsetValues = sp.offsets;
endmodule
`default_nettype wire

// >>> include/mq_pkg.sv
package mq_pkg;
   localparam int NUM_Q = 4;
   localparam int LANE_W = 10;
   localparam int WORD_W = 20;
   localparam int BUS_W = 40;
   localparam int DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;
   // Flag register stages per mode
   localparam int FLAG_STAGES_STD = 2;
   localparam int FLAG_STAGES_FALL_THROUGH_MODE = 3;
   // Offset registers: four empty and four full offsets
   localparam int OFFSET_W = 16;
   localparam int NUM_OFFSETS = 8;
   localparam int SCAN_W = OFFSET_W * NUM_OFFSETS;
   localparam logic [OFFSET_W-1:0] OFFSET_DEFAULT = 16'h007f;
   // Wait after power-down release
   localparam int CLK_PERIOD_NS = 40;
   localparam int PD_RESUME_NS = 1000;
   localparam int PD_RESUME_CYC = (PD_RESUME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] PD_RESUME_CNT = 5'(PD_RESUME_CYC);
   // Lane placement on the output bus
   localparam int Q0_BASE = 0;
   localparam int Q2_BASE = 20;
   typedef enum logic [1:0] {MODE_QUAD, MODE_DUAL10, MODE_DUAL20} bus_mode_t;
   typedef enum logic {SER_IDLE, SER_SCAN} scan_state_t;
endpackage

// >>> include/offset_port_if.sv
`timescale 1ns/1ns
`default_nettype none
interface offset_port_if;
   logic sclk;
   logic serialIn;
   logic swenN;
   logic srenN;
   logic pdActive;
   logic serialOut;
   logic serialOutOeN;
   logic [mq_pkg::SCAN_W-1:0] offsets;
   modport port (
      input sclk, serialIn, swenN, srenN, pdActive,
      output serialOut, serialOutOeN, offsets
   );
   modport top (
      output sclk, serialIn, swenN, srenN, pdActive,
      input serialOut, serialOutOeN, offsets
   );
endinterface
`default_nettype wire

// >>> rtl/offset_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
module offset_serial_port (
   // Clock and reset
   input wire logic clk,
   input wire logic rstN,
   // Serial side
   offset_port_if.port sp
);
   logic sclkPrev_reg;
   logic [mq_pkg::SCAN_W-1:0] offsets_reg;
   logic [mq_pkg::SCAN_W-1:0] scan_reg;
   mq_pkg::scan_state_t state_reg;
   logic sclkRise;

   ////////////////////////////////////////////////////////////
   // Serial clock edge, frozen in power-down
   assign sclkRise = !sp.pdActive && sp.sclk && !sclkPrev_reg;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sclkPrev_reg <= 1'b0;
      end else if (!sp.pdActive) begin
         sclkPrev_reg <= sp.sclk;
      end
   end

   ////////////////////////////////////////////////////////////
   // Offset load
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         offsets_reg <= {mq_pkg::NUM_OFFSETS{mq_pkg::OFFSET_DEFAULT}};
      end else if (sclkRise && !sp.swenN) begin
         offsets_reg <= {offsets_reg[mq_pkg::SCAN_W-2:0], sp.serialIn};
      end
   end

   ////////////////////////////////////////////////////////////
   // Scan-out copy and shift
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= mq_pkg::SER_IDLE;
         scan_reg <= '0;
      end else if (!sp.pdActive) begin
         case (state_reg)
            mq_pkg::SER_IDLE: begin
               if (!sp.srenN) begin
                  scan_reg <= offsets_reg;
                  state_reg <= mq_pkg::SER_SCAN;
               end
            end
            mq_pkg::SER_SCAN: begin
               if (sp.srenN) begin
                  state_reg <= mq_pkg::SER_IDLE;
               end else if (sclkRise) begin
                  scan_reg <= {scan_reg[mq_pkg::SCAN_W-2:0], 1'b0};
               end
            end
            default: state_reg <= mq_pkg::SER_IDLE;
         endcase
      end
   end

   assign sp.serialOut = scan_reg[mq_pkg::SCAN_W-1];
   assign sp.serialOutOeN = sp.pdActive;
   assign sp.offsets = offsets_reg;
endmodule
`default_nettype wire

// >>> tb/mq_read_properties.sv
`timescale 1ns/1ns
`default_nettype none
module mq_read_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Watched ports
   input wire logic power_down_n,
   input wire logic [3:0] readClk,
   input wire logic [3:0] read_chip_select_n,
   input wire logic [3:0] outputEnableN,
   input wire logic [39:0] queueDataOeN,
   input wire logic [39:0] queueData,
   input wire logic [3:0] empty_flag_n,
   input wire logic resumeReady,
   input wire logic serialClk,
   input wire logic fall_through_or_serial_in,
   input wire logic offset_shift_write_enable_n,
   input wire logic offset_shift_read_enable_n,
   input wire logic offset_serial_out,
   input wire logic offsetSerialOutOeN,
   input wire logic [127:0] offsetValues
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence serRise;
      $rose(serialClk) && power_down_n;
   endsequence
   sequence pdHeld;
      !power_down_n [*3];
   endsequence
   ////////////////////////////////////////
   AST_RST_OE: assert property (disable iff (!power_down_n)
      !rstn && $past(!rstn) |-> queueDataOeN[9:0] == {10{outputEnableN[0]}})
      else $error("lanes ignore drive enable in reset");
   AST_PD_FLOAT: assert property (!power_down_n [*2] |-> &queueDataOeN && offsetSerialOutOeN)
      else $error("outputs driven in power-down");
   AST_PD_FREEZE: assert property (pdHeld |-> $stable(offsetValues) && $stable(empty_flag_n)
      && $stable(queueData)) else $error("state moved in power-down");
   AST_OE_FLOAT: assert property (outputEnableN[0] && power_down_n |-> &queueDataOeN[9:0])
      else $error("lanes driven with drive enable high");
   AST_OFFSET_SHIFT_WRITE_ENABLE_N_HOLD: assert property (offset_shift_write_enable_n && $past(offset_shift_write_enable_n)
      |-> $stable(offsetValues)) else $error("offsets changed while write disabled");
   AST_OFFSET_SHIFT_WRITE_ENABLE_N_SHIFT: assert property (serRise ##0 !offset_shift_write_enable_n
      |=> offsetValues == {$past(offsetValues[126:0]), $past(fall_through_or_serial_in)})
      else $error("offset shift wrong");
   AST_SCAN_COPY: assert property ($fell(offset_shift_read_enable_n) && power_down_n
      |=> offset_serial_out == $past(offsetValues[127])) else $error("scan copy wrong");
   AST_CS_FLOAT: assert property ($rose(readClk[0]) && read_chip_select_n[0] && power_down_n
      |=> &queueDataOeN[9:0]) else $error("lanes driven with chip select high");
   AST_RESUME: assert property ($rose(power_down_n) |-> !resumeReady [*8] ##17 !resumeReady ##1 resumeReady)
      else $error("resume wait wrong");
endmodule
bind multi_queue_read_ctrl mq_read_properties i_mq_read_properties (.core_clk, .rstn, .power_down_n, .readClk,
   .read_chip_select_n, .outputEnableN, .queueDataOeN, .queueData, .empty_flag_n, .resumeReady, .serialClk,
   .fall_through_or_serial_in, .offset_shift_write_enable_n, .offset_shift_read_enable_n, .offset_serial_out,
   .offsetSerialOutOeN, .offsetValues);
`default_nettype wire

// >>> tb/mq_reader_model.sv
`timescale 1ns/1ns
`default_nettype none
module mq_reader_model (
   // Clock
   input wire logic core_clk,
   // Read side
   output logic [3:0] readClk,
   output logic [3:0] readEnableN,
   output logic [3:0] read_chip_select_n,
   // Serial side
   output logic serialClk,
   output logic fall_through_or_serial_in,
   output logic offset_shift_write_enable_n,
   output logic offset_shift_read_enable_n,
   input wire logic offset_serial_out
);
   initial begin
      readClk = '0;
      readEnableN = '1;
      read_chip_select_n = '0;
      serialClk = 1'b0;
      fall_through_or_serial_in = 1'b0;
      offset_shift_write_enable_n = 1'b1;
      offset_shift_read_enable_n = 1'b1;
   end
   ////////////////////////////////////////
   // One slow read clock cycle
   task automatic rclk(input int q, input logic renN, input logic csN);
      @(posedge core_clk);
      readClk[q] <= 1'b1;
      readEnableN[q] <= renN;
      read_chip_select_n[q] <= csN;
      repeat (2) @(posedge core_clk);
      readClk[q] <= 1'b0;
      readEnableN[q] <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask
   // One serial clock cycle, output bit taken before the rise
   task automatic sbit(input logic d, input logic swenN, input logic srenN, output logic q);
      @(posedge core_clk);
      fall_through_or_serial_in <= d;
      offset_shift_write_enable_n <= swenN;
      offset_shift_read_enable_n <= srenN;
      repeat (2) @(posedge core_clk);
      q = offset_serial_out;
      serialClk <= 1'b1;
      repeat (2) @(posedge core_clk);
      serialClk <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic power_down_n = 1'b1;
   logic quadMode = 1'b1;
   logic [3:0] outputEnableN = '0;
   logic [3:0] wrValid = '0;
   logic [3:0][19:0] wrData = '0;
   logic [3:0] wrReady, readClk, readEnableN, read_chip_select_n, empty_flag_n;
   logic [39:0] queueData, queueDataOeN;
   logic resumeReady, serialClk, serialIn, swenN, srenN, serialOut, serialOutOeN, b;
   logic [127:0] offsetValues, expOffsets, got;
   logic [15:0] pat = 16'hc3a5;
   int errCount = 0;
   int numChecks = 0;
   int n;
   always #20 core_clk = ~core_clk;
   multi_queue_read_ctrl i_multi_queue_read_ctrl (.core_clk, .rstn, .partialResetN(1'b1),
      .read_double_rate_select(1'b0), .quadMode, .dualWide(1'b0), .power_down_n,
      .readClk, .readEnableN, .read_chip_select_n, .outputEnableN, .wrValid, .wrData, .wrReady,
      .queueData, .queueDataOeN, .empty_flag_n, .resumeReady, .serialClk, .fall_through_or_serial_in(serialIn),
      .offset_shift_write_enable_n(swenN), .offset_shift_read_enable_n(srenN), .offset_serial_out(serialOut),
      .offsetSerialOutOeN(serialOutOeN), .offsetValues);
   mq_reader_model i_mq_reader_model (.core_clk, .readClk, .readEnableN, .read_chip_select_n, .serialClk,
      .fall_through_or_serial_in(serialIn), .offset_shift_write_enable_n(swenN),
      .offset_shift_read_enable_n(srenN), .offset_serial_out(serialOut));
   ////////////////////////////////////////
   task automatic check(input logic [127:0] g, input logic [127:0] e);
      numChecks++;
      if (g !== e) begin
         errCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic put(input int q, input logic [19:0] d);
      @(posedge core_clk);
      wrValid[q] <= 1'b1;
      wrData[q] <= d;
      @(posedge core_clk);
      wrValid[q] <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(offsetValues, {8{mq_pkg::OFFSET_DEFAULT}});
      check(empty_flag_n, 4'h0);
      $display("reset test done");
      for (int q = 0; q < 4; q++) begin
         put(q, 20'h002c0 + 20'(q));
         i_mq_reader_model.rclk(q, 1'b1, 1'b0);
         check(empty_flag_n[q], 1'b0);
         i_mq_reader_model.rclk(q, 1'b1, 1'b0);
         check(empty_flag_n[q], 1'b1);
         i_mq_reader_model.rclk(q, 1'b0, 1'b0);
         check(queueData[q*10 +: 10], 10'h2c0 + 10'(q));
         check(empty_flag_n[q], 1'b0);
         i_mq_reader_model.rclk(q, 1'b0, 1'b0);
         check(queueData[q*10 +: 10], 10'h2c0 + 10'(q));
      end
      $display("lane test done");
      outputEnableN[0] <= 1'b1;
      @(posedge core_clk);
      @(posedge core_clk);
      check(queueDataOeN[9:0], 10'h3ff);
      outputEnableN[0] <= 1'b0;
      @(posedge core_clk);
      @(posedge core_clk);
      check(queueDataOeN[9:0], 10'h000);
      i_mq_reader_model.rclk(0, 1'b1, 1'b1);
      check(queueDataOeN[9:0], 10'h3ff);
      i_mq_reader_model.rclk(0, 1'b1, 1'b0);
      check(queueDataOeN[9:0], 10'h000);
      $display("drive test done");
      expOffsets = {{7{mq_pkg::OFFSET_DEFAULT}}, pat};
      for (int i = 15; i >= 0; i--) i_mq_reader_model.sbit(pat[i], 1'b0, 1'b1, b);
      check(offsetValues, expOffsets);
      repeat (2) i_mq_reader_model.sbit(~pat[0], 1'b1, 1'b1, b);
      check(offsetValues, expOffsets);
      for (int i = 127; i >= 0; i--) begin
         i_mq_reader_model.sbit(~pat[0], 1'b1, 1'b0, b);
         got[i] = b;
      end
      check(got, expOffsets);
      i_mq_reader_model.sbit(~pat[0], 1'b1, 1'b1, b);
      for (int i = 127; i >= 118; i--) begin
         i_mq_reader_model.sbit(~pat[0], 1'b1, 1'b0, b);
         got[i] = b;
      end
      check(got[127:118], expOffsets[127:118]);
      i_mq_reader_model.sbit(~pat[0], 1'b1, 1'b1, b);
      $display("serial test done");
      put(0, 20'h00155);
      repeat (4) i_mq_reader_model.rclk(0, 1'b1, 1'b0);
      check(queueData[9:0], 10'h2c0);
      check(empty_flag_n[0], 1'b1);
      @(posedge core_clk);
      power_down_n <= 1'b0;
      i_mq_reader_model.rclk(0, 1'b0, 1'b0);
      i_mq_reader_model.sbit(1'b1, 1'b0, 1'b1, b);
      check(queueDataOeN, 40'hffffffffff);
      check(serialOutOeN, 1'b1);
      check(offsetValues, expOffsets);
      check({empty_flag_n[0], queueData[9:0]}, {1'b1, 10'h2c0});
      power_down_n <= 1'b1;
      for (n = 0; n < 100 && resumeReady !== 1'b1; n++) @(posedge core_clk);
      if (n == 100) begin
         errCount++;
         end_of_test();
      end
      i_mq_reader_model.rclk(0, 1'b0, 1'b0);
      check(queueData[9:0], 10'h155);
      $display("power-down test done");
      i_mq_reader_model.sbit(1'b1, 1'b1, 1'b1, b);
      rstn <= 1'b0;
      quadMode <= 1'b0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(empty_flag_n, 4'hf);
      check(queueDataOeN, 40'hffc00ffc00);
      check(wrReady, 4'h5);
      put(0, 20'h002a7);
      repeat (2) i_mq_reader_model.rclk(0, 1'b1, 1'b0);
      check(empty_flag_n[0], 1'b1);
      i_mq_reader_model.rclk(0, 1'b1, 1'b0);
      check({empty_flag_n[0], queueData[9:0]}, {1'b0, 10'h2a7});
      i_mq_reader_model.rclk(0, 1'b0, 1'b0);
      check({empty_flag_n[0], queueData[9:0]}, {1'b1, 10'h2a7});
      $display("fall-through test done");
      end_of_test();
   end
endmodule
`default_nettype wire
